// file: hdl/drive_alarm_map.vh
// Constants for the drive alarm manager: register map, fields, codes, timing.
// Assumes inclusion by its bare name from the design file.
`ifndef DRIVE_ALARM_MAP_VH
`define DRIVE_ALARM_MAP_VH

// Register byte offsets
`define OFF_STATUS        8'h00
`define OFF_CONFIG        8'h04
`define OFF_AR_DELAY      8'h08
`define OFF_DI_FUNC       8'h0c
`define OFF_SER_TIMEOUT   8'h10
`define OFF_LIMIT_TIME    8'h14
`define OFF_IRQ_STATUS    8'h18
`define OFF_IRQ_MASK      8'h1c

// Status fields
`define STAT_CODE_MSB     4
`define STAT_ACTIVE_BIT   8
// Config fields
`define CFG_AR_EN_BIT     0
`define CFG_EXT_AUTO_BIT  1
`define CFG_TORQUE_AUTO_BIT 2
// Interrupt fields
`define IRQ_RAISED_BIT    0
`define IRQ_CLEARED_BIT   1

// Reset values
`define RST_CONFIG        32'h0000_0000
`define RST_AR_DELAY      32'h0000_0100
`define RST_DI_FUNC       32'h0000_0000
`define RST_SER_TIMEOUT   32'h0000_0000
`define RST_LIMIT_TIME    32'h0000_1000
`define RST_IRQ_MASK      2'h0

// Digital input function selections
`define DI_FN_EXT_NO      3'h1
`define DI_FN_EXT_NC      3'h2
`define DI_FN_ALARM_RESET 3'h5
`define DI_FN_BITS        3

// Alarm serial codes
`define CODE_NONE         5'h00
`define CODE_EXT_FAULT    5'h01
`define CODE_OVERCURRENT  5'h02
`define CODE_OVERVOLT     5'h03
`define CODE_UNDERVOLT    5'h04
`define CODE_OVER_TORQUE  5'h09
`define CODE_SER_TIMEOUT  5'h0d
`define CODE_MAX          21

// Timing
`define CLK_HZ            64'd200000000
`define PHASE_LOSS_S      64'd30

// Bus answers
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// file: hdl/drive_alarm_manager.v
// Alarm latch, coding and reset logic of a motor drive, with an AXI4-Lite slave.
// Assumes fault inputs synchronous to clk; keypad and digital inputs may be asynchronous.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "drive_alarm_map.vh"

module drive_alarm_manager #(
   parameter        NUM_DI            = 4,
   parameter [39:0] PHASE_LOSS_CYCLES = 40'd6000000000
) (
   input  wire        clk,
   input  wire        rst,
   input  wire [7:0]  awaddr,
   input  wire        awvalid,
   output reg         awready,
   input  wire [31:0] wdata,
   input  wire [3:0]  wstrb,
   input  wire        wvalid,
   output reg         wready,
   output reg  [1:0]  bresp,
   output reg         bvalid,
   input  wire        bready,
   input  wire [7:0]  araddr,
   input  wire        arvalid,
   output reg         arready,
   output reg  [31:0] rdata,
   output reg  [1:0]  rresp,
   output reg         rvalid,
   input  wire        rready,
   input  wire        drive_enabled,
   input  wire        key_up,
   input  wire        key_down,
   input  wire [NUM_DI-1:0] digital_in,
   input  wire        output_overcurrent_alarm,
   input  wire        bus_overvoltage_alarm,
   input  wire        bus_undervoltage_alarm,
   input  wire        heatsink_switch_overtemp_alarm,
   input  wire        drive_overload_alarm,
   input  wire        motor_overload_alarm,
   input  wire        brake_resistor_overload_alarm,
   input  wire        over_torque_alarm,
   input  wire        supply_phase_missing,
   input  wire        switch_desaturation_alarm,
   input  wire        serial_activity,
   input  wire        option_one_comm_alarm,
   input  wire        option_two_comm_alarm,
   input  wire        comm_bus_failure_alarm,
   input  wire        heatsink_analog_overtemp_alarm,
   input  wire        output_short_alarm,
   input  wire        board_overtemp_alarm,
   input  wire        limit_state,
   input  wire        temp_sensor_failure_alarm,
   output reg         alarm_output,
   output reg  [4:0]  alarm_code,
   output reg         irq
);

   // Long count; the figure stays a parameter so a bench can shorten it
   localparam [63:0] PHASE_LOSS_DOC = `PHASE_LOSS_S * `CLK_HZ;

   function [31:0] merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0]  strb;
      integer      b;
      begin
         merge = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b]) begin
               merge[8*b +: 8] = data[8*b +: 8];
            end
         end
      end
   endfunction

   // Lowest code wins when several faults trip together
   function [4:0] first_code;
      input [`CODE_MAX:1] v;
      integer             i;
      begin
         first_code = `CODE_NONE;
         for (i = `CODE_MAX; i >= 1; i = i - 1) begin
            if (v[i]) begin
               first_code = i[4:0];
            end
         end
      end
   endfunction

   function mapped;
      input [7:0] a;
      begin
         mapped = (a[1:0] == 2'h0) && (a <= `OFF_IRQ_MASK);
      end
   endfunction

   reg  [31:0] config_reg;
   reg  [31:0] ar_delay;
   reg  [31:0] di_func;
   reg  [31:0] ser_timeout;
   reg  [31:0] limit_time;
   reg  [1:0]  irq_status;
   reg  [1:0]  irq_mask;
   reg  [7:0]  aw_addr_q;
   reg         aw_held;
   reg  [31:0] w_data_q;
   reg  [3:0]  w_strb_q;
   reg         w_held;
   reg  [31:0] read_word;

   wire wr_go = aw_held & w_held & ~bvalid;
   wire wr_ok = wr_go & mapped(aw_addr_q);

   // Write side: address and data taken in either order
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         awready   <= 1'b0;
         wready    <= 1'b0;
         aw_held   <= 1'b0;
         w_held    <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
         bvalid    <= 1'b0;
         bresp     <= `RESP_OKAY;
      end else begin
         awready <= ~aw_held & ~(awvalid & awready) & ~bvalid;
         wready  <= ~w_held & ~(wvalid & wready) & ~bvalid;
         if (awvalid & awready) begin
            aw_held   <= 1'b1;
            aw_addr_q <= awaddr;
         end
         if (wvalid & wready) begin
            w_held   <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bvalid & bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always @* begin
      case (araddr)
         `OFF_STATUS:      read_word = {23'h0, alarm_output, 3'h0, alarm_code};
         `OFF_CONFIG:      read_word = config_reg;
         `OFF_AR_DELAY:    read_word = ar_delay;
         `OFF_DI_FUNC:     read_word = di_func;
         `OFF_SER_TIMEOUT: read_word = ser_timeout;
         `OFF_LIMIT_TIME:  read_word = limit_time;
         `OFF_IRQ_STATUS:  read_word = {30'h0, irq_status};
         `OFF_IRQ_MASK:    read_word = {30'h0, irq_mask};
         default:          read_word = 32'h0000_0000;
      endcase
   end

   // Read side: one word per request, answered the cycle after it is taken
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= `RESP_OKAY;
      end else begin
         arready <= ~rvalid & ~(arvalid & arready);
         if (arvalid & arready) begin
            rvalid <= 1'b1;
            rdata  <= read_word;
            rresp  <= mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rvalid & rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         config_reg  <= `RST_CONFIG;
         ar_delay    <= `RST_AR_DELAY;
         di_func     <= `RST_DI_FUNC;
         ser_timeout <= `RST_SER_TIMEOUT;
         limit_time  <= `RST_LIMIT_TIME;
         irq_mask    <= `RST_IRQ_MASK;
      end else if (wr_ok) begin
         case (aw_addr_q)
            `OFF_CONFIG:      config_reg  <= merge(config_reg, w_data_q, w_strb_q);
            `OFF_AR_DELAY:    ar_delay    <= merge(ar_delay, w_data_q, w_strb_q);
            `OFF_DI_FUNC:     di_func     <= merge(di_func, w_data_q, w_strb_q);
            `OFF_SER_TIMEOUT: ser_timeout <= merge(ser_timeout, w_data_q, w_strb_q);
            `OFF_LIMIT_TIME:  limit_time  <= merge(limit_time, w_data_q, w_strb_q);
            `OFF_IRQ_MASK:    irq_mask    <= w_strb_q[0] ? w_data_q[1:0] : irq_mask;
            default:          irq_mask    <= irq_mask;
         endcase
      end
   end

   // Two-stage synchronisers; only the second stage is looked at
   reg  [1:0]        key_meta;
   reg  [1:0]        key_sync;
   reg  [NUM_DI-1:0] di_meta;
   reg  [NUM_DI-1:0] di_sync;
   reg  [NUM_DI-1:0] di_prev;
   reg               chord;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         key_meta <= 2'h0;
         key_sync <= 2'h0;
         di_meta  <= {NUM_DI{1'b0}};
         di_sync  <= {NUM_DI{1'b0}};
         di_prev  <= {NUM_DI{1'b0}};
      end else begin
         key_meta <= {key_up, key_down};
         key_sync <= key_meta;
         di_meta  <= digital_in;
         di_sync  <= di_meta;
         di_prev  <= di_sync;
      end
   end

   reg          di_reset_edge;
   reg          ext_fault_active;
   integer      k;

   always @* begin
      di_reset_edge    = 1'b0;
      ext_fault_active = 1'b0;
      for (k = 0; k < NUM_DI; k = k + 1) begin
         if (di_func[k*`DI_FN_BITS +: `DI_FN_BITS] == `DI_FN_ALARM_RESET) begin
            di_reset_edge = di_reset_edge | (di_sync[k] & ~di_prev[k]);
         end
         if (di_func[k*`DI_FN_BITS +: `DI_FN_BITS] == `DI_FN_EXT_NO) begin
            ext_fault_active = ext_fault_active | di_sync[k];
         end
         if (di_func[k*`DI_FN_BITS +: `DI_FN_BITS] == `DI_FN_EXT_NC) begin
            ext_fault_active = ext_fault_active | ~di_sync[k];
         end
      end
   end

   // Chord is armed while both keys are down, fires when both are up again
   wire key_release = chord & (key_sync == 2'h0);

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         chord <= 1'b0;
      end else if (key_sync == 2'h3) begin
         chord <= 1'b1;
      end else if (key_sync == 2'h0) begin
         chord <= 1'b0;
      end
   end

   // Timed detectors
   reg  [39:0] phase_cnt;
   reg  [31:0] ser_cnt;
   reg  [31:0] limit_cnt;

   wire phase_trip = supply_phase_missing && (phase_cnt >= PHASE_LOSS_CYCLES);
   wire ser_trip   = (ser_timeout != 32'h0) && (ser_cnt > ser_timeout);
   wire limit_trip = limit_state && (limit_cnt >= limit_time);

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_cnt <= 40'h0;
         ser_cnt   <= 32'h0;
         limit_cnt <= 32'h0;
      end else begin
         if (!supply_phase_missing) begin
            phase_cnt <= 40'h0;
         end else if (!phase_trip) begin
            phase_cnt <= phase_cnt + 40'h1;
         end
         if (serial_activity || ser_timeout == 32'h0) begin
            ser_cnt <= 32'h0;
         end else if (!ser_trip) begin
            ser_cnt <= ser_cnt + 32'h1;
         end
         if (!limit_state) begin
            limit_cnt <= 32'h0;
         end else if (!limit_trip) begin
            limit_cnt <= limit_cnt + 32'h1;
         end
      end
   end

   wire [`CODE_MAX:1] trips = {
      temp_sensor_failure_alarm,
      limit_trip,
      board_overtemp_alarm,
      output_short_alarm,
      heatsink_analog_overtemp_alarm,
      comm_bus_failure_alarm,
      option_two_comm_alarm,
      option_one_comm_alarm,
      ser_trip,
      switch_desaturation_alarm,
      1'b0,
      phase_trip,
      over_torque_alarm,
      brake_resistor_overload_alarm,
      motor_overload_alarm,
      drive_overload_alarm,
      heatsink_switch_overtemp_alarm,
      bus_undervoltage_alarm,
      bus_overvoltage_alarm,
      output_overcurrent_alarm,
      ext_fault_active};

   wire [4:0] next_code = first_code(trips);

   // Eligible set: fixed YES codes plus the two settable ones
   wire eligible = (alarm_code == `CODE_OVERCURRENT) || (alarm_code == `CODE_OVERVOLT) ||
                   (alarm_code == `CODE_UNDERVOLT) || (alarm_code == `CODE_SER_TIMEOUT) ||
                   (alarm_code == `CODE_EXT_FAULT && config_reg[`CFG_EXT_AUTO_BIT]) ||
                   (alarm_code == `CODE_OVER_TORQUE && config_reg[`CFG_TORQUE_AUTO_BIT]);

   reg  [31:0] ar_cnt;
   wire        auto_clear = alarm_output & eligible & config_reg[`CFG_AR_EN_BIT] &
                            (ar_cnt >= ar_delay);
   // Manual clears are blocked outright while running
   wire        manual_clear = alarm_output & ~drive_enabled &
                              (key_release | di_reset_edge);
   wire        clear_now = auto_clear | manual_clear;
   wire        raise_now = ~alarm_output & (next_code != `CODE_NONE);

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ar_cnt <= 32'h0;
      end else if (!alarm_output || clear_now) begin
         ar_cnt <= 32'h0;
      end else if (ar_cnt < ar_delay) begin
         ar_cnt <= ar_cnt + 32'h1;
      end
   end

   // First alarm is held; later faults do not overwrite its code
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         alarm_output <= 1'b0;
         alarm_code   <= `CODE_NONE;
      end else if (clear_now) begin
         alarm_output <= 1'b0;
         alarm_code   <= `CODE_NONE;
      end else if (raise_now) begin
         alarm_output <= 1'b1;
         alarm_code   <= next_code;
      end
   end

   // Sticky events; a new event beats a write-one clear in the same cycle
   wire       clr_irq = wr_ok && (aw_addr_q == `OFF_IRQ_STATUS) && w_strb_q[0];
   wire [1:0] irq_clr = clr_irq ? w_data_q[1:0] : 2'h0;
   wire [1:0] irq_set = {clear_now, raise_now};
   wire [1:0] next_irq_status = (irq_status & ~irq_clr) | irq_set;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_status <= 2'h0;
         irq        <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq        <= |(next_irq_status & irq_mask);
      end
   end

endmodule

// file: bench/field_side.sv
// Model of the keypad, digital input lines and fault detectors.
// Assumes request lines are driven just after rising edges of clk.
`timescale 1ns/10ps
module field_side (
   input  wire        clk,
   input  wire        chord_go,
   input  wire [18:0] fault_set,
   input  wire [3:0]  di_set,
   output reg         key_up,
   output reg         key_down,
   output reg  [3:0]  digital_in,
   output reg  [18:0] fault_line
);
   reg [3:0] hold;
   initial begin
      hold = 4'h0;
      key_up = 1'b0;
      key_down = 1'b0;
      digital_in = 4'h4;
      fault_line = 19'h0;
   end
   always @(posedge clk) begin
      digital_in <= di_set;
      fault_line <= fault_set;
      if (chord_go) begin
         hold <= 4'h4;
      end else if (hold != 4'h0) begin
         hold <= hold - 4'h1;
      end
      // Both keys go down and up on the same edge
      key_up <= hold != 4'h0;
      key_down <= hold != 4'h0;
   end
endmodule

// file: bench/drive_alarm_checker.sv
// Checker for the alarm manager: code latch, clears and bus latency.
// Assumes a bind to drive_alarm_manager, one clock domain.
`timescale 1ns/10ps
module drive_alarm_checker (
   input wire       clk,
   input wire       rst,
   input wire       awvalid,
   input wire       awready,
   input wire       wvalid,
   input wire       wready,
   input wire       bvalid,
   input wire       arvalid,
   input wire       arready,
   input wire       rvalid,
   input wire       drive_enabled,
   input wire       key_up,
   input wire       key_down,
   input wire       output_overcurrent_alarm,
   input wire       bus_overvoltage_alarm,
   input wire       alarm_output,
   input wire [4:0] alarm_code
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence s_chord_release;
      key_up && key_down ##1 !key_up && !key_down;
   endsequence
   property p_code_zero;
      !alarm_output |-> alarm_code == 5'h00;
   endproperty
   a_code_zero: assert property (p_code_zero) else $error("code not zero while idle");
   property p_code_active;
      alarm_output |-> alarm_code != 5'h00;
   endproperty
   a_code_active: assert property (p_code_active) else $error("alarm without code");
   property p_code_stable;
      alarm_output && $past(alarm_output) |-> alarm_code == $past(alarm_code);
   endproperty
   a_code_stable: assert property (p_code_stable) else $error("latched code changed");
   property p_ovv_latch;
      !alarm_output && bus_overvoltage_alarm && !output_overcurrent_alarm |=> alarm_output && alarm_code == 5'h03;
   endproperty
   a_ovv_latch: assert property (p_ovv_latch) else $error("overvoltage not latched");
   property p_no_clear_en;
      alarm_output && alarm_code == 5'h05 && drive_enabled |=> alarm_output;
   endproperty
   a_no_clear_en: assert property (p_no_clear_en) else $error("alarm cleared while enabled");
   // Sync delay of the keys allows a few cycles
   property p_key_clear;
      s_chord_release ##0 (alarm_output && !drive_enabled) |-> ##[1:8] !alarm_output;
   endproperty
   a_key_clear: assert property (p_key_clear) else $error("keypad chord did not clear");
   property p_read_lat;
      arvalid && arready |=> rvalid;
   endproperty
   a_read_lat: assert property (p_read_lat) else $error("read answer late");
   property p_write_lat;
      awvalid && awready && wvalid && wready |=> ##1 bvalid;
   endproperty
   a_write_lat: assert property (p_write_lat) else $error("write answer late");
endmodule
bind drive_alarm_manager drive_alarm_checker u_checker (.clk, .rst, .awvalid, .awready, .wvalid, .wready,
   .bvalid, .arvalid, .arready, .rvalid, .drive_enabled, .key_up, .key_down, .output_overcurrent_alarm,
   .bus_overvoltage_alarm, .alarm_output, .alarm_code);

// file: bench/tb_top.sv
// Testbench of the alarm manager: register bus tasks and alarm scenarios.
// Assumes field_side as the far side and the bound checker.
`timescale 1ns/10ps
`include "drive_alarm_map.vh"
module tb_top;
   reg         clk, rst, awvalid, wvalid, bready, arvalid, rready, drive_enabled, chord_go;
   reg  [7:0]  awaddr, araddr;
   reg  [31:0] wdata, rd;
   reg  [3:0]  wstrb, di_set;
   reg  [18:0] fault_set;
   reg  [1:0]  rsp;
   wire        awready, wready, bvalid, arready, rvalid, key_up, key_down, alarm_output, irq;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   wire [4:0]  alarm_code;
   wire [3:0]  digital_in;
   wire [18:0] f;
   integer     bad_count = 0, compares = 0, i;
   reg  [4:0]  codes [0:15];
   reg  [31:0] rstv [0:6];

   field_side u_field (.clk(clk), .chord_go(chord_go), .fault_set(fault_set), .di_set(di_set),
      .key_up(key_up), .key_down(key_down), .digital_in(digital_in), .fault_line(f));
   // Short phase loss count keeps the run brief
   drive_alarm_manager #(.PHASE_LOSS_CYCLES(40'd50)) DUT (.clk(clk), .rst(rst), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .drive_enabled(drive_enabled), .key_up(key_up), .key_down(key_down), .digital_in(digital_in),
      .output_overcurrent_alarm(f[0]), .bus_overvoltage_alarm(f[1]), .bus_undervoltage_alarm(f[2]),
      .heatsink_switch_overtemp_alarm(f[3]), .drive_overload_alarm(f[4]), .motor_overload_alarm(f[5]),
      .brake_resistor_overload_alarm(f[6]), .over_torque_alarm(f[7]), .switch_desaturation_alarm(f[8]),
      .option_one_comm_alarm(f[9]), .option_two_comm_alarm(f[10]), .comm_bus_failure_alarm(f[11]),
      .heatsink_analog_overtemp_alarm(f[12]), .output_short_alarm(f[13]), .board_overtemp_alarm(f[14]),
      .temp_sensor_failure_alarm(f[15]), .supply_phase_missing(f[16]), .limit_state(f[17]),
      .serial_activity(f[18]), .alarm_output(alarm_output), .alarm_code(alarm_code), .irq(irq));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task chk(input string n, input [31:0] e, input [31:0] g);
      compares = compares + 1;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", n, e, g);
         bad_count = bad_count + 1;
      end
   endtask

   task wr(input [7:0] a, input [31:0] d);
      reg a_d, w_d;
      a_d = 1'b0;
      w_d = 1'b0;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(a_d && w_d)) begin
         @(posedge clk);
         if (awready && !a_d) begin
            a_d = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready && !w_d) begin
            w_d = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (!bvalid);
      rsp = bresp;
   endtask

   task rd_reg(input [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
      rd = rdata;
      rsp = rresp;
   endtask

   task chord;
      chord_go <= 1'b1;
      @(posedge clk);
      chord_go <= 1'b0;
      repeat (12) @(posedge clk);
   endtask

   task fault_pulse(input integer b);
      fault_set <= 19'h1 << b;
      repeat (3) @(posedge clk);
      fault_set <= 19'h0;
      repeat (3) @(posedge clk);
   endtask

   task final_report;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      #(5 * 20000);
      bad_count = bad_count + 1;
      final_report;
   end

   initial begin
      codes = '{5'd2, 5'd3, 5'd4, 5'd5, 5'd6, 5'd7, 5'd8, 5'd9, 5'd12, 5'd14, 5'd15, 5'd16, 5'd17, 5'd18,
         5'd19, 5'd21};
      rstv = '{`RST_CONFIG, `RST_AR_DELAY, `RST_DI_FUNC, `RST_SER_TIMEOUT, `RST_LIMIT_TIME, 32'h0, 32'h0};
      {awvalid, wvalid, bready, arvalid, rready, drive_enabled, chord_go} = 7'h0;
      {awaddr, araddr, wdata, wstrb, fault_set} = 71'h0;
      di_set = 4'h4;
      rst = 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (i = 0; i < 7; i = i + 1) begin
         rd_reg(8'h04 + 8'h04 * i);
         chk("reset value", rstv[i], rd);
      end
      rd_reg(8'h40);
      chk("unmapped resp", {30'h0, `RESP_SLVERR}, {30'h0, rsp});
      wr(8'h40, 32'h1);
      chk("unmapped wr resp", {30'h0, `RESP_SLVERR}, {30'h0, rsp});
      // Input 0 clears, input 1 external fault NO, input 2 external fault NC
      wr(`OFF_DI_FUNC, 32'h8d);
      fault_pulse(1);
      chk("irq masked", 0, irq);
      wr(`OFF_IRQ_MASK, 32'h1);
      rd_reg(`OFF_STATUS);
      chk("status", 32'h103, rd);
      chk("irq", 1, irq);
      chord;
      chk("code after chord", 0, alarm_code);
      wr(`OFF_IRQ_STATUS, 32'h3);
      rd_reg(`OFF_IRQ_STATUS);
      chk("irq status", 0, rd);
      chk("irq cleared", 0, irq);
      for (i = 0; i < 16; i = i + 1) begin
         fault_pulse(i);
         chk("fault code", codes[i], alarm_code);
         chord;
         chk("alarm output", 0, alarm_output);
      end
      di_set <= 4'h6;
      repeat (6) @(posedge clk);
      chk("ext fault NO", 1, alarm_code);
      di_set <= 4'h0;
      chord;
      chk("ext fault NC", 1, alarm_code);
      di_set <= 4'h4;
      chord;
      fault_pulse(4);
      di_set <= 4'h5;
      repeat (8) @(posedge clk);
      chk("input clear", 0, alarm_code);
      fault_pulse(5);
      repeat (4) @(posedge clk);
      chk("held input", 7, alarm_code);
      di_set <= 4'h4;
      repeat (4) @(posedge clk);
      di_set <= 4'h5;
      repeat (8) @(posedge clk);
      chk("second edge", 0, alarm_code);
      fault_set <= 19'h10000;
      repeat (40) @(posedge clk);
      chk("phase early", 0, alarm_code);
      repeat (20) @(posedge clk);
      chk("phase loss", 10, alarm_code);
      fault_set <= 19'h0;
      chord;
      wr(`OFF_LIMIT_TIME, 32'd20);
      fault_set <= 19'h20000;
      repeat (30) @(posedge clk);
      chk("limit state", 20, alarm_code);
      fault_set <= 19'h40000;
      chord;
      wr(`OFF_SER_TIMEOUT, 32'd30);
      repeat (40) @(posedge clk);
      chk("serial busy", 0, alarm_code);
      fault_set <= 19'h0;
      repeat (40) @(posedge clk);
      chk("serial timeout", 13, alarm_code);
      wr(`OFF_SER_TIMEOUT, 32'h0);
      chord;
      wr(`OFF_AR_DELAY, 32'd10);
      wr(`OFF_CONFIG, 32'h5);
      fault_pulse(7);
      repeat (15) @(posedge clk);
      chk("torque auto", 0, alarm_code);
      wr(`OFF_CONFIG, 32'h1);
      fault_pulse(7);
      repeat (20) @(posedge clk);
      chk("torque kept", 9, alarm_code);
      chord;
      drive_enabled <= 1'b1;
      fault_pulse(2);
      chk("undervoltage", 4, alarm_code);
      repeat (15) @(posedge clk);
      chk("autoreset", 0, alarm_code);
      fault_pulse(3);
      repeat (30) @(posedge clk);
      chk("no autoreset", 5, alarm_code);
      chord;
      chk("chord enabled", 5, alarm_code);
      di_set <= 4'h4;
      repeat (4) @(posedge clk);
      di_set <= 4'h5;
      repeat (8) @(posedge clk);
      chk("input enabled", 5, alarm_code);
      drive_enabled <= 1'b0;
      chord;
      chk("chord disabled", 0, alarm_code);
      final_report;
   end
endmodule
